// ==== rtl/event_xfer_pkg.sv ====
// Shared constants and types of the event transfer engine.
package event_xfer_pkg;
   localparam int         APB_AW     = 8;
   localparam int         SRC_W      = 8;
   localparam int         BASE_LOW_W = 10;
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] BASE_OFS   = 8'h04;
   localparam logic [7:0] STAT_OFS   = 8'h08;
   localparam int         CTRL_STOP  = 0;
   localparam int         CTRL_RSKIP = 1;
   localparam int         CTRL_FWD   = 2;
   // Descriptor word 0 fields.
   localparam int         W0_MODE    = 0;
   localparam int         W0_SIZE    = 2;
   localparam int         W0_SM      = 4;
   localparam int         W0_DM      = 6;
   localparam int         W0_RPT_SRC = 8;
   localparam int         W0_CHAIN   = 9;
   localparam int         W0_CHCOND  = 10;
   localparam int         W0_EACH    = 11;
   localparam int         W0_SHORT   = 12;
   // Descriptor word 3 fields: counter, current repeat count, reload size.
   localparam int         W3_CNT     = 0;
   localparam int         W3_CUR     = 16;
   localparam int         W3_RLD     = 24;
   localparam logic [31:0] OFS_SA    = 32'h4;
   localparam logic [31:0] OFS_DA    = 32'h8;
   localparam logic [31:0] OFS_CNT   = 32'hc;
   localparam logic [31:0] DESC_BYTES = 32'h10;
   localparam logic [8:0] MAX_UNITS  = 9'h100;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_REPEAT = 2'h1;
   localparam logic [1:0] MODE_BLOCK  = 2'h2;
   localparam logic [1:0] SIZE_BYTE   = 2'h0;
   localparam logic [1:0] SIZE_WORD   = 2'h1;
   localparam logic [1:0] SIZE_LONG   = 2'h2;
   localparam int         SHORT_MSB   = 23;
   typedef enum logic [3:0] {
      ST_IDLE, ST_VEC, ST_D0, ST_D1, ST_D2, ST_D3, ST_RD, ST_WR, ST_WS, ST_WD, ST_WC
   } state_e;
endpackage

// ==== rtl/addr_stepper.sv ====
// Next-address calculation for one side of a transfer.
`timescale 1ns/1ps
module addr_stepper (
   input  wire logic [31:0] addr_in,
   input  wire logic [1:0]  mode_in,
   input  wire logic [1:0]  size_in,
   input  wire logic        restore_in,
   input  wire logic [8:0]  reload_in,
   input  wire logic        short_in,
   output logic [31:0]      next_out
);
   import event_xfer_pkg::*;
   logic [31:0] unit;
   logic [31:0] back;
   logic [31:0] stepped;
   logic [31:0] moved;
   assign unit = 32'h1 << size_in;
   assign back = {23'h0, reload_in} << size_in;
   // Mode bit 0 selects decrement; mode bit 1 clear means the address is fixed.
   assign stepped = mode_in[0] ? addr_in - unit : addr_in + unit;
   // Restore walks the area back to its start once the repeat area is done.
   assign moved = !restore_in ? stepped : (mode_in[0] ? stepped + back : stepped - back);
   assign next_out = !mode_in[1] ? addr_in :
                     short_in ? {{8{moved[SHORT_MSB]}}, moved[SHORT_MSB:0]} : moved;
endmodule

// ==== rtl/event_transfer_engine.sv ====
// Event transfer engine: activation intake, descriptor walk, data moves and APB registers.
`timescale 1ns/1ps
// Contract
// - Normal mode moves exactly one data unit per accepted activation.
// - Repeat mode moves one unit, reloading the repeating address after the repeat size.
// - Repeat size ranges up to 256 units per area.
// - Block mode moves a whole block per activation.
// - Block size is one to 256 units.
// - Each requesting source selects its own descriptor channel.
// - Chained channels run in sequence on one activation.
// - Chain runs always, or only when the counter reached zero.
// - Short addresses reach the low and high 8 MB halves.
// - Full addresses use all 32 bits.
// - Units are byte, word or longword.
// - Activation may be forwarded to the CPU.
// - A CPU interrupt may follow every single unit.
// - A CPU interrupt may follow completion of the programmed count.
// - Read skip reuses held descriptor for the same source.
// - Fixed addresses are not written back.
// - Module stop accepts no activations until released.
// - Vector base keeps its low 10 bits at zero; only the upper bits are stored.
module event_transfer_engine (
   input  wire logic                              clk_in,
   input  wire logic                              nrst_in,
   input  wire logic                              psel_in,
   input  wire logic                              penable_in,
   input  wire logic                              pwrite_in,
   input  wire logic [event_xfer_pkg::APB_AW-1:0] paddr_in,
   input  wire logic [31:0]                       pwdata_in,
   output logic [31:0]                            prdata_out,
   output logic                                   pready_out,
   output logic                                   pslverr_out,
   input  wire logic                              act_req_in,
   input  wire logic [event_xfer_pkg::SRC_W-1:0]  act_src_in,
   output logic                                   act_ack_out,
   output logic                                   mem_req_out,
   output logic                                   mem_we_out,
   output logic [31:0]                            mem_addr_out,
   output logic [1:0]                             mem_size_out,
   output logic [31:0]                            mem_wdata_out,
   input  wire logic [31:0]                       mem_rdata_in,
   input  wire logic                              mem_ack_in,
   output logic                                   cpu_irq_out,
   output logic [event_xfer_pkg::SRC_W-1:0]       cpu_irq_src_out,
   output logic                                   busy_out
);
   import event_xfer_pkg::*;

   typedef struct packed {
      state_e      st;
      logic        stop;
      logic        rskip;
      logic        fwd;
      logic [21:0] base;
      logic [7:0]  src_id;
      logic        held;
      logic        link;
      logic        fin;
      logic [7:0]  held_id;
      logic [31:0] daddr;
      logic [31:0] w0;
      logic [31:0] sa;
      logic [31:0] da;
      logic [31:0] w3;
      logic [8:0]  blk;
      logic [31:0] maddr;
      logic        mwe;
      logic [1:0]  msize;
      logic [31:0] mwdata;
      logic        irq;
      logic [7:0]  irq_src;
      logic [31:0] prdata;
      logic        pslverr;
   } xfer_state_s;

   xfer_state_s q_r;
   xfer_state_s q_nxt;

   logic [1:0]  mode;
   logic [1:0]  usize;
   logic [1:0]  smode;
   logic [1:0]  dmode;
   logic        rpt_src;
   logic        chain;
   logic        chcond;
   logic        each;
   logic        short_m;
   logic [15:0] cnt_dec;
   logic [8:0]  cur_n;
   logic [8:0]  rld_n;
   logic [8:0]  rld_d3;
   logic        area_end;
   logic [31:0] sa_next;
   logic [31:0] da_next;
   logic [31:0] rdata_unit;
   logic        skip_hit;
   logic        chain_go;

   assign mode    = q_r.w0[W0_MODE+:2];
   assign usize   = q_r.w0[W0_SIZE+:2];
   assign smode   = q_r.w0[W0_SM+:2];
   assign dmode   = q_r.w0[W0_DM+:2];
   assign rpt_src = q_r.w0[W0_RPT_SRC];
   assign chain   = q_r.w0[W0_CHAIN];
   assign chcond  = q_r.w0[W0_CHCOND];
   assign each    = q_r.w0[W0_EACH];
   assign short_m = q_r.w0[W0_SHORT];
   assign cnt_dec = q_r.w3[W3_CNT+:16] - 16'h1;
   // A zero size field stands for the largest area of 256 units.
   assign cur_n   = (q_r.w3[W3_CUR+:8] == 8'h0) ? MAX_UNITS : {1'b0, q_r.w3[W3_CUR+:8]};
   assign rld_n   = (q_r.w3[W3_RLD+:8] == 8'h0) ? MAX_UNITS : {1'b0, q_r.w3[W3_RLD+:8]};
   assign rld_d3  = (mem_rdata_in[W3_RLD+:8] == 8'h0) ? MAX_UNITS : {1'b0, mem_rdata_in[W3_RLD+:8]};
   assign area_end = (mode == MODE_REPEAT) && (cur_n == 9'h1);
   assign rdata_unit = (usize == SIZE_BYTE) ? {24'h0, mem_rdata_in[7:0]} :
                       (usize == SIZE_WORD) ? {16'h0, mem_rdata_in[15:0]} : mem_rdata_in;
   assign skip_hit = q_r.rskip && q_r.held && (q_r.held_id == act_src_in);
   assign chain_go = chain && (!chcond || (q_r.w3[W3_CNT+:16] == 16'h0));

   addr_stepper u_src_step (
      .addr_in    (q_r.sa),
      .mode_in    (smode),
      .size_in    (usize),
      .restore_in (area_end && rpt_src),
      .reload_in  (rld_n),
      .short_in   (short_m),
      .next_out   (sa_next)
   );

   addr_stepper u_dst_step (
      .addr_in    (q_r.da),
      .mode_in    (dmode),
      .size_in    (usize),
      .restore_in (area_end && !rpt_src),
      .reload_in  (rld_n),
      .short_in   (short_m),
      .next_out   (da_next)
   );

   function automatic xfer_state_s issue(input xfer_state_s s, input state_e st,
                                         input logic [31:0] addr, input logic we,
                                         input logic [31:0] data);
      xfer_state_s r;
      r = s;
      r.st = st;
      r.maddr = addr;
      r.mwe = we;
      r.mwdata = data;
      r.msize = (st == ST_RD || st == ST_WR) ? s.w0[W0_SIZE+:2] : SIZE_LONG;
      return r;
   endfunction

   function automatic logic [31:0] shorten(input logic [31:0] a, input logic s);
      return s ? {{8{a[SHORT_MSB]}}, a[SHORT_MSB:0]} : a;
   endfunction

   // In module stop an idle engine acknowledges no activation, so it stays idle.
   assign act_ack_out = (q_r.st == ST_IDLE) && act_req_in && !q_r.stop;

   always_comb begin
      q_nxt = q_r;
      q_nxt.irq = 1'b0;
      case (q_r.st)
         ST_IDLE: begin
            if (act_ack_out) begin
               q_nxt.src_id = act_src_in;
               q_nxt.link = 1'b0;
               if (q_r.fwd) begin
                  q_nxt.irq = 1'b1;
                  q_nxt.irq_src = act_src_in;
               end
               if (skip_hit) begin
                  q_nxt.blk = rld_n;
                  q_nxt = issue(q_nxt, ST_RD, q_r.sa, 1'b0, 32'h0);
               end else begin
                  q_nxt = issue(q_nxt, ST_VEC, {q_r.base, act_src_in, 2'b00}, 1'b0, 32'h0);
               end
            end
         end
         ST_VEC: begin
            if (mem_ack_in) begin
               q_nxt.daddr = mem_rdata_in;
               q_nxt = issue(q_nxt, ST_D0, mem_rdata_in, 1'b0, 32'h0);
            end
         end
         ST_D0: begin
            if (mem_ack_in) begin
               q_nxt.w0 = mem_rdata_in;
               q_nxt = issue(q_nxt, ST_D1, q_r.daddr + OFS_SA, 1'b0, 32'h0);
            end
         end
         ST_D1: begin
            if (mem_ack_in) begin
               q_nxt.sa = shorten(mem_rdata_in, short_m);
               q_nxt = issue(q_nxt, ST_D2, q_r.daddr + OFS_DA, 1'b0, 32'h0);
            end
         end
         ST_D2: begin
            if (mem_ack_in) begin
               q_nxt.da = shorten(mem_rdata_in, short_m);
               q_nxt = issue(q_nxt, ST_D3, q_r.daddr + OFS_CNT, 1'b0, 32'h0);
            end
         end
         ST_D3: begin
            if (mem_ack_in) begin
               q_nxt.w3 = mem_rdata_in;
               q_nxt.blk = rld_d3;
               q_nxt = issue(q_nxt, ST_RD, q_r.sa, 1'b0, 32'h0);
            end
         end
         ST_RD: begin
            if (mem_ack_in) begin
               q_nxt = issue(q_nxt, ST_WR, q_r.da, 1'b1, rdata_unit);
            end
         end
         ST_WR: begin
            if (mem_ack_in) begin
               q_nxt.sa = sa_next;
               q_nxt.da = da_next;
               case (mode)
                  MODE_REPEAT: begin
                     // The repeating side address is restored by the stepper.
                     q_nxt.w3[W3_CUR+:8] = area_end ? q_r.w3[W3_RLD+:8]
                                                    : 8'(cur_n - 9'h1);
                  end
                  MODE_BLOCK: begin
                     q_nxt.blk = q_r.blk - 9'h1;
                     if (q_r.blk == 9'h1) begin
                        q_nxt.w3[W3_CNT+:16] = cnt_dec;
                     end
                  end
                  default: begin
                     q_nxt.w3[W3_CNT+:16] = cnt_dec;
                  end
               endcase
               q_nxt.fin = (mode == MODE_NORMAL || (mode == MODE_BLOCK && q_r.blk == 9'h1))
                           && (cnt_dec == 16'h0);
               if (each) begin
                  q_nxt.irq = 1'b1;
                  q_nxt.irq_src = q_r.src_id;
               end
               if (mode == MODE_BLOCK && q_r.blk != 9'h1) begin
                  q_nxt = issue(q_nxt, ST_RD, sa_next, 1'b0, 32'h0);
               end else if (smode[1]) begin
                  q_nxt = issue(q_nxt, ST_WS, q_r.daddr + OFS_SA, 1'b1, sa_next);
               end else if (dmode[1]) begin
                  q_nxt = issue(q_nxt, ST_WD, q_r.daddr + OFS_DA, 1'b1, da_next);
               end else begin
                  q_nxt = issue(q_nxt, ST_WC, q_r.daddr + OFS_CNT, 1'b1, q_nxt.w3);
               end
            end
         end
         ST_WS: begin
            if (mem_ack_in) begin
               if (dmode[1]) begin
                  q_nxt = issue(q_nxt, ST_WD, q_r.daddr + OFS_DA, 1'b1, q_r.da);
               end else begin
                  q_nxt = issue(q_nxt, ST_WC, q_r.daddr + OFS_CNT, 1'b1, q_r.w3);
               end
            end
         end
         ST_WD: begin
            if (mem_ack_in) begin
               q_nxt = issue(q_nxt, ST_WC, q_r.daddr + OFS_CNT, 1'b1, q_r.w3);
            end
         end
         ST_WC: begin
            if (mem_ack_in) begin
               if (q_r.fin) begin
                  q_nxt.irq = 1'b1;
                  q_nxt.irq_src = q_r.src_id;
               end
               if (chain_go) begin
                  q_nxt.link = 1'b1;
                  q_nxt.held = 1'b0;
                  q_nxt.daddr = q_r.daddr + DESC_BYTES;
                  q_nxt = issue(q_nxt, ST_D0, q_r.daddr + DESC_BYTES, 1'b0, 32'h0);
               end else begin
                  q_nxt.st = ST_IDLE;
                  q_nxt.mwe = 1'b0;
                  q_nxt.held = !q_r.link;
                  q_nxt.held_id = q_r.src_id;
               end
            end
         end
         default: begin
            q_nxt.st = ST_IDLE;
         end
      endcase
      // Read data is captured in the setup phase so it stands through the access phase.
      if (psel_in && !penable_in) begin
         q_nxt.prdata = 32'h0;
         q_nxt.pslverr = 1'b0;
         if (paddr_in == CTRL_OFS) begin
            q_nxt.prdata = {29'h0, q_r.fwd, q_r.rskip, q_r.stop};
         end else if (paddr_in == BASE_OFS) begin
            q_nxt.prdata = {q_r.base, 10'h000};
         end else if (paddr_in == STAT_OFS) begin
            q_nxt.prdata = {8'h0, q_r.held_id, q_r.src_id, 5'h0, q_r.held,
                            q_r.stop && (q_r.st == ST_IDLE), q_r.st != ST_IDLE};
         end else begin
            q_nxt.pslverr = 1'b1;
         end
      end
      // Register writes come last so a base write or a read-skip clear always invalidates a held descriptor.
      if (psel_in && penable_in && pwrite_in) begin
         if (paddr_in == CTRL_OFS) begin
            q_nxt.stop = pwdata_in[CTRL_STOP];
            q_nxt.rskip = pwdata_in[CTRL_RSKIP];
            q_nxt.fwd = pwdata_in[CTRL_FWD];
            if (!pwdata_in[CTRL_RSKIP]) begin
               q_nxt.held = 1'b0;
            end
         end else if (paddr_in == BASE_OFS) begin
            q_nxt.base = pwdata_in[31:BASE_LOW_W];
            q_nxt.held = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign prdata_out      = q_r.prdata;
   assign pready_out      = 1'b1;
   assign pslverr_out     = q_r.pslverr;
   assign mem_req_out     = q_r.st != ST_IDLE;
   assign mem_we_out      = q_r.mwe;
   assign mem_addr_out    = q_r.maddr;
   assign mem_size_out    = q_r.msize;
   assign mem_wdata_out   = q_r.mwdata;
   assign cpu_irq_out     = q_r.irq;
   assign cpu_irq_src_out = q_r.irq_src;
   assign busy_out        = q_r.st != ST_IDLE;

   stop_blocks_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.stop && q_r.st == ST_IDLE) |-> !act_ack_out ##1 (q_r.st == ST_IDLE))
      else $error("activation taken in stop");
   vec_addr_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      q_r.st == ST_VEC |-> mem_addr_out == {q_r.base, q_r.src_id, 2'b00})
      else $error("vector address wrong");
   normal_single_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.st == ST_WR && mem_ack_in && mode == MODE_NORMAL) |=> q_r.st != ST_RD)
      else $error("normal mode moved a second unit");
   block_loop_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.st == ST_WR && mem_ack_in && mode == MODE_BLOCK && q_r.blk != 9'h1)
      |=> q_r.st == ST_RD && mem_addr_out == $past(sa_next)) else $error("block ended early");
   block_size_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.st == ST_RD && mode == MODE_BLOCK) |-> q_r.blk >= 9'h1 && q_r.blk <= MAX_UNITS)
      else $error("block count out of range");
   repeat_reload_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.st == ST_WR && mem_ack_in && area_end)
      |=> q_r.w3[W3_CUR+:8] == $past(q_r.w3[W3_RLD+:8])) else $error("repeat count not reloaded");
   chain_go_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.st == ST_WC && mem_ack_in && chain_go)
      |=> q_r.st == ST_D0 && mem_addr_out == $past(q_r.daddr) + DESC_BYTES)
      else $error("chain not followed");
   chain_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.st == ST_WC && mem_ack_in && chain && chcond && q_r.w3[15:0] != 16'h0)
      |=> q_r.st == ST_IDLE) else $error("conditional chain ran early");
   short_space_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.st == ST_RD && short_m) |-> (mem_addr_out[31:SHORT_MSB] == 9'h0
      || mem_addr_out[31:SHORT_MSB] == 9'h1ff)) else $error("short address out of space");
   unit_size_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.st == ST_RD || q_r.st == ST_WR) |-> mem_size_out == usize)
      else $error("unit size mismatch");
   irq_each_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.st == ST_WR && mem_ack_in && each) |=> cpu_irq_out) else $error("no per-unit irq");
   irq_end_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.st == ST_WC && mem_ack_in && q_r.fin) |=> cpu_irq_out) else $error("no end irq");
   irq_fwd_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (act_ack_out && q_r.fwd) |=> cpu_irq_out && cpu_irq_src_out == $past(act_src_in))
      else $error("activation not forwarded");
   skip_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (act_ack_out && skip_hit) |=> q_r.st == ST_RD) else $error("read skip ignored");
   wb_skip_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (q_r.st == ST_WS |-> smode[1]) and (q_r.st == ST_WD |-> dmode[1]))
      else $error("fixed address written back");
   wb_count_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      q_r.st == ST_WC |-> mem_we_out && mem_addr_out == q_r.daddr + OFS_CNT)
      else $error("counter write-back wrong");
endmodule

// ==== verif/mem_partner.sv ====
// Memory partner that answers the engine's data bus with varying latency.
`timescale 1ns/1ps
module mem_partner (
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic        req_in,
   input  wire logic        we_in,
   input  wire logic [31:0] addr_in,
   input  wire logic [1:0]  size_in,
   input  wire logic [31:0] wdata_in,
   output logic [31:0]      rdata_out,
   output logic             ack_out
);
   logic [31:0] ram [logic [31:0]];
   int          wr_cnt [logic [31:0]];
   int          wait_c;
   int          turn;
   logic [31:0] word;
   // Latency cycles through 0, 1 and 2; read data turns over in the cycle after each acknowledge.
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ack_out <= 1'b0;
         rdata_out <= 32'h0;
         wait_c = 0;
         turn = 0;
      end else if (ack_out) begin
         ack_out <= 1'b0;
         rdata_out <= ~rdata_out;
      end else if (req_in && wait_c > 0) begin
         wait_c = wait_c - 1;
      end else if (req_in) begin
         ack_out <= 1'b1;
         turn = turn + 1;
         wait_c = turn % 3;
         word = ram.exists(addr_in) ? ram[addr_in] : 32'h0;
         if (we_in) begin
            ram[addr_in] = wdata_in;
            wr_cnt[addr_in] = wr_cnt.exists(addr_in) ? wr_cnt[addr_in] + 1 : 1;
         end else begin
            rdata_out <= size_in == 2'h0 ? word & 32'hff :
                         size_in == 2'h1 ? word & 32'hffff : word;
         end
      end
   end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench: APB registers, activations and descriptor walks.
`timescale 1ns/1ps
module testbench;
   import event_xfer_pkg::*;
   logic        clk_in, nrst_in, psel_in, penable_in, pwrite_in, act_req_in, err;
   logic        pready_out, pslverr_out, act_ack_out, mem_req_out, mem_we_out;
   logic        mem_ack_in, cpu_irq_out, busy_out;
   logic [7:0]  paddr_in, act_src_in, cpu_irq_src_out;
   logic [1:0]  mem_size_out;
   logic [31:0] pwdata_in, prdata_out, mem_rdata_in, mem_addr_out, mem_wdata_out, rd;
   logic [31:0] v [4];
   int          failures = 0;
   int          compares = 0;
   int          irqs = 0;
   int          seed;
   event_transfer_engine uut (.clk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .act_req_in,
      .act_src_in, .act_ack_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_size_out,
      .mem_wdata_out, .mem_rdata_in, .mem_ack_in, .cpu_irq_out, .cpu_irq_src_out, .busy_out);
   mem_partner mem (.clk_in, .nrst_in, .req_in(mem_req_out), .we_in(mem_we_out),
      .addr_in(mem_addr_out), .size_in(mem_size_out), .wdata_in(mem_wdata_out),
      .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   always @(posedge clk_in) irqs <= irqs + int'(cpu_irq_out === 1'b1);
   task final_report;
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task guard(inout int k);
      k++;
      if (k > 3000) begin
         failures++;
         $display("CHECK FAILED at %0t: wait ran out", $time);
         final_report();
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin @(posedge clk_in); guard(k); end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task act(input logic [7:0] s);
      int k;
      k = 0;
      act_req_in <= 1'b1;
      act_src_in <= s;
      // The acknowledge is combinational, so it is looked at before the edge that takes it.
      do begin @(negedge clk_in); guard(k); end while (act_ack_out !== 1'b1);
      @(posedge clk_in);
      act_req_in <= 1'b0;
      do begin @(posedge clk_in); guard(k); end while (busy_out !== 1'b0);
      repeat (2) @(posedge clk_in);
   endtask
   task desc(input logic [31:0] p, input logic [31:0] w0, input logic [31:0] w1,
             input logic [31:0] w2, input logic [31:0] w3);
      mem.ram[p] = w0;
      mem.ram[p + OFS_SA] = w1;
      mem.ram[p + OFS_DA] = w2;
      mem.ram[p + OFS_CNT] = w3;
   endtask
   initial begin
      seed = 44;
      {nrst_in, psel_in, penable_in, pwrite_in, act_req_in} = 5'h0;
      {paddr_in, act_src_in, pwdata_in} = 48'h0;
      for (int i = 0; i < 4; i++) v[i] = $random(seed);
      for (int i = 0; i < 4; i++) mem.ram[32'h414 + 4 * i] = 32'h1000 + 32'h100 * i;
      for (int i = 0; i < 4; i++) mem.ram[32'h2100 + i] = v[i];
      desc(32'h1000, 32'h18a8, 32'h2000, 32'h00803000, 32'h3);
      desc(32'h1100, 32'ha2, 32'h2100, 32'h3100, 32'h04040001);
      desc(32'h1200, 32'h688, 32'h2200, 32'h3200, 32'h1);
      desc(32'h1210, 32'ha8, 32'h2300, 32'h3300, 32'h2);
      desc(32'h1300, 32'h129, 32'h2400, 32'h3400, 32'h0202000a);
      {mem.ram[32'h2000], mem.ram[32'h2004], mem.ram[32'h2200]} = {v[0], v[3], v[1]};
      {mem.ram[32'h2300], mem.ram[32'h2400], mem.ram[32'h2404]} = {v[2], v[0], v[3]};
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      apb(1'b0, CTRL_OFS, 32'h0); chk(rd, 32'h0, "control reset");
      apb(1'b0, BASE_OFS, 32'h0); chk(rd, 32'h0, "base reset");
      apb(1'b0, STAT_OFS, 32'h0); chk(rd, 32'h0, "status reset");
      apb(1'b0, 8'h0c, 32'h0); chk({31'h0, err}, 32'h1, "unmapped error");
      apb(1'b1, BASE_OFS, 32'hffffffff);
      apb(1'b0, BASE_OFS, 32'h0); chk(rd, 32'hfffffc00, "base low bits");
      apb(1'b1, BASE_OFS, 32'h400);
      $display("test registers done");
      act(8'h5);
      chk(mem.ram[32'hff803000], v[0], "normal data");
      chk(mem.wr_cnt.exists(32'hff803004), 32'h0, "single unit");
      chk(mem.ram[32'h1004], 32'h2004, "source written back");
      chk(mem.ram[32'h1008], 32'hff803004, "short destination written back");
      chk(mem.ram[32'h100c] & 32'hffff, 32'h2, "counter written back");
      chk(irqs, 32'h1, "unit interrupt");
      chk(cpu_irq_src_out, 32'h5, "interrupt source");
      $display("test normal done");
      apb(1'b1, CTRL_OFS, 32'h4);
      act(8'h6);
      apb(1'b1, CTRL_OFS, 32'h0);
      for (int i = 0; i < 4; i++) chk(mem.ram[32'h3100 + i], v[i] & 32'hff, "block byte");
      chk(mem.ram[32'h110c] & 32'hffff, 32'h0, "block counter");
      chk(irqs, 32'h3, "forward and end interrupts");
      $display("test block done");
      act(8'h7);
      chk(mem.ram[32'h3200], v[1], "chain first");
      chk(mem.ram[32'h3300], v[2], "chain second");
      chk(mem.wr_cnt.exists(32'h1204), 32'h0, "fixed source kept");
      act(8'h7);
      chk(mem.ram[32'h3204], v[1], "second unit of first channel");
      chk(mem.wr_cnt.exists(32'h3304), 32'h0, "conditional chain held");
      $display("test chain done");
      apb(1'b1, CTRL_OFS, 32'h1);
      act_req_in <= 1'b1;
      repeat (20) begin @(negedge clk_in); chk(act_ack_out, 32'h0, "stopped ack"); end
      @(posedge clk_in);
      act_req_in <= 1'b0;
      apb(1'b0, STAT_OFS, 32'h0); chk(rd & 32'h2, 32'h2, "stopped flag");
      apb(1'b1, CTRL_OFS, 32'h0);
      act(8'h5);
      chk(mem.ram[32'hff803004], v[3], "after release");
      $display("test stop done");
      apb(1'b1, CTRL_OFS, 32'h2);
      act(8'h8);
      chk(mem.ram[32'h1304], 32'h2404, "repeat advance");
      apb(1'b0, STAT_OFS, 32'h0); chk(rd & 32'hff0004, 32'h080004, "held descriptor");
      act(8'h8);
      chk(mem.ram[32'h1304], 32'h2400, "repeat reload");
      chk(mem.ram[32'h3400], v[3], "repeat data");
      $display("test repeat done");
      final_report();
   end
endmodule
